// ### epr_pkg.sv
package epr_pkg;

	// Mode field encodings
	localparam logic [4:0] MODE_USR = 5'h10;
	localparam logic [4:0] MODE_FIQ = 5'h11;
	localparam logic [4:0] MODE_IRQ = 5'h12;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_ABT = 5'h17;
	localparam logic [4:0] MODE_UND = 5'h1b;

	// Exception vectors
	localparam logic [31:0] VEC_RESET = 32'h0000_0000;
	localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
	localparam logic [31:0] VEC_SWTRAP = 32'h0000_0008;
	localparam logic [31:0] VEC_PABT = 32'h0000_000c;
	localparam logic [31:0] VEC_DABT = 32'h0000_0010;
	localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
	localparam logic [31:0] VEC_FIQ = 32'h0000_001c;

	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam logic [31:0] LINK_OFS = 32'h0000_0004;
	localparam logic [31:0] LINK_OFS_DABT = 32'h0000_0008;

	// Latency budget, in processor cycles
	localparam int T_SYNC_MIN_CYC = 2;
	localparam int T_SYNC_MAX_CYC = 3;
	localparam int T_LDM_CYC = 20;
	localparam int T_EXC_CYC = 3;
	localparam int T_FIQ_CYC = 2;
	localparam int FIQ_LAT_MAX_CYC = T_SYNC_MAX_CYC + T_LDM_CYC + T_EXC_CYC
		+ T_FIQ_CYC;
	localparam int LAT_MIN_CYC = T_SYNC_MIN_CYC + T_FIQ_CYC;
	localparam int CNT_W = 2;

	// Saved-state banks
	localparam int NUM_BANKS = 5;
	localparam logic [2:0] BANK_FIQ = 3'h0;
	localparam logic [2:0] BANK_IRQ = 3'h1;
	localparam logic [2:0] BANK_SVC = 3'h2;
	localparam logic [2:0] BANK_ABT = 3'h3;
	localparam logic [2:0] BANK_UND = 3'h4;

	// Decode fields
	localparam logic [2:0] OPC_UNDEF_CLASS = 3'h3;
	localparam logic [3:0] OPC_SWTRAP = 4'hf;

	// APB register offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_FETCH = 8'h04;
	localparam logic [7:0] REG_CAUSE = 8'h08;
	localparam logic [7:0] REG_SVC_LINK = 8'h0c;
	localparam logic [7:0] REG_SVC_SAVED = 8'h10;

	typedef struct packed {
		logic [3:0] flags;
		logic [19:0] rsv;
		logic irqMask;
		logic fiqMask;
		logic compact;
		logic [4:0] mode;
	} epr_status_type;

	localparam epr_status_type STATUS_RESET = '{flags: 4'h0, rsv: 20'h0,
		irqMask: 1'b1, fiqMask: 1'b1, compact: 1'b0, mode: MODE_SVC};

	typedef enum logic [2:0] {
		EXC_NONE, EXC_RESET, EXC_DABT, EXC_FIQ, EXC_IRQ, EXC_PABT,
		EXC_UNDEF, EXC_SWTRAP
	} epr_exc_type;

	typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_ENTRY} epr_state_type;

	typedef struct packed {
		logic coreReset_b;
		logic fastIrq_b;
		logic normIrq_b;
	} epr_pins_type;

	localparam epr_pins_type PINS_RESET = '{coreReset_b: 1'b0,
		fastIrq_b: 1'b1, normIrq_b: 1'b1};

endpackage

// ### epr_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module epr_sync2
	import epr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire epr_pins_type asyncIn,
	output epr_pins_type syncOut
);
	epr_pins_type stage1_r;
	epr_pins_type stage2_r;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage1_r <= PINS_RESET;
			stage2_r <= PINS_RESET;
		end else if (ce) begin
			stage1_r <= asyncIn;
			stage2_r <= stage1_r;
		end
	end

	assign syncOut = stage2_r;
endmodule
`default_nettype wire

// ### epr_exception_unit.sv
// Functional notes
// - Arbitrate reset, data abort, fast, normal, prefetch abort, then traps.
// - Undefined and software trap never both raised for one instruction.
// - Data abort with unmasked fast interrupt chains into fast vector.
// - Fast interrupt latency at most 28 cycles including abort entry.
// - After worst-case latency the core fetches from fast vector 0x1c.
// - Least latency for either interrupt is four cycles.
// - Normal interrupt waits while fast interrupt handling continues.
// - While core reset is low, fetch walks incrementing word addresses.
// - Reset release copies fetch address and status into supervisor bank.
// - Reset release forces supervisor mode, both masks, compact bit clear.
// - After reset release, fetch starts at zero in 32-bit state.
// - Multiply with bit 6 set does not raise undefined trap.
// - Exception entry saves status, forces mode, loads vector.
// - Each exception has its own fixed vector address.
// - Fast interrupt entry masks normal interrupts.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module epr_exception_unit
	import epr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic coreReset_b,
	input wire logic fastIrq_b,
	input wire logic normIrq_b,
	input wire logic instrBoundary,
	input wire logic [31:0] instrWord,
	input wire logic instrCondPass,
	input wire logic instrPrefetchAbort,
	input wire logic [31:0] instrAddr,
	input wire logic dataAbort,
	input wire logic excReturn,
	input wire logic [31:0] returnAddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] fetchAddr,
	output logic pcLoad,
	output epr_exc_type takenCause,
	output epr_status_type statusWord,
	output logic entryBusy,
	output logic [31:0] supervisorLinkRegister,
	output epr_status_type supervisorSavedStatus
);
	epr_pins_type pinRaw;
	epr_pins_type pinSync;
	logic entryBusy_r;
	epr_state_type state_r;
	logic [CNT_W-1:0] cnt_r;
	epr_exc_type curCause_r;
	epr_exc_type takenCause_r;
	epr_exc_type nextCause;
	epr_exc_type entryCause;
	epr_status_type statusWord_r;
	epr_status_type savedStatus_r [NUM_BANKS];
	logic [31:0] linkReg_r [NUM_BANKS];
	logic [31:0] fetchAddr_r;
	logic pcLoad_r;
	logic dabtPend_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic coreSync;
	logic fiqReq;
	logic irqReq;
	logic pabtHit;
	logic undefHit;
	logic swHit;
	logic takeNow;
	logic finishEntry;
	logic chainFiq;
	logic entryStart;
	logic resetRelease;
	logic returnTake;
	logic saveEn;
	logic [2:0] saveBank;
	logic [31:0] saveLink;
	logic statusWrite;
	logic [31:0] readData;
	logic addrHit;

	function automatic logic [4:0] modeOf(input epr_exc_type c);
		case (c)
			EXC_DABT, EXC_PABT: modeOf = MODE_ABT;
			EXC_FIQ: modeOf = MODE_FIQ;
			EXC_IRQ: modeOf = MODE_IRQ;
			EXC_UNDEF: modeOf = MODE_UND;
			default: modeOf = MODE_SVC;
		endcase
	endfunction

	function automatic logic [31:0] vecOf(input epr_exc_type c);
		case (c)
			EXC_UNDEF: vecOf = VEC_UNDEF;
			EXC_SWTRAP: vecOf = VEC_SWTRAP;
			EXC_PABT: vecOf = VEC_PABT;
			EXC_DABT: vecOf = VEC_DABT;
			EXC_IRQ: vecOf = VEC_IRQ;
			EXC_FIQ: vecOf = VEC_FIQ;
			default: vecOf = VEC_RESET;
		endcase
	endfunction

	function automatic logic [2:0] bankOf(input logic [4:0] m);
		case (m)
			MODE_FIQ: bankOf = BANK_FIQ;
			MODE_IRQ: bankOf = BANK_IRQ;
			MODE_ABT: bankOf = BANK_ABT;
			MODE_UND: bankOf = BANK_UND;
			default: bankOf = BANK_SVC;
		endcase
	endfunction

	// Counter preload: entry lasts the full figure incl. the vector load edge
	function automatic logic [CNT_W-1:0] entryLoad(input epr_exc_type c);
		if (c == EXC_DABT) begin
			entryLoad = CNT_W'(T_EXC_CYC - 2);
		end else begin
			entryLoad = CNT_W'(T_FIQ_CYC - 2);
		end
	endfunction

	assign pinRaw = '{coreReset_b: coreReset_b, fastIrq_b: fastIrq_b,
		normIrq_b: normIrq_b};

	epr_sync2 u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.asyncIn(pinRaw),
		.syncOut(pinSync)
	);

	assign coreSync = pinSync.coreReset_b;
	assign fiqReq = !pinSync.fastIrq_b && !statusWord_r.fiqMask;
	// Set I bit keeps normal interrupts out during fast handling
	assign irqReq = !pinSync.normIrq_b && !statusWord_r.irqMask;
	assign pabtHit = instrBoundary && instrPrefetchAbort;
	// Class 011 with bit 4 set; multiply space is never in this class
	assign undefHit = instrBoundary && instrCondPass && !instrPrefetchAbort
		&& instrWord[27:25] == OPC_UNDEF_CLASS && instrWord[4];
	// Exclusive by encoding alone, so the trap assertion sees the decode
	assign swHit = instrBoundary && instrCondPass && !instrPrefetchAbort
		&& instrWord[27:24] == OPC_SWTRAP;

	always_comb begin
		nextCause = EXC_NONE;
		if (dabtPend_r) begin
			nextCause = EXC_DABT;
		end else if (fiqReq) begin
			nextCause = EXC_FIQ;
		end else if (irqReq) begin
			nextCause = EXC_IRQ;
		end else if (pabtHit) begin
			nextCause = EXC_PABT;
		end else if (undefHit) begin
			nextCause = EXC_UNDEF;
		end else if (swHit) begin
			nextCause = EXC_SWTRAP;
		end
	end

	assign resetRelease = state_r == ST_RESET && coreSync;
	assign takeNow = coreSync && state_r == ST_RUN && instrBoundary
		&& nextCause != EXC_NONE;
	assign finishEntry = coreSync && state_r == ST_ENTRY && cnt_r == '0;
	// Abort entry leaves F alone, so an unmasked fast request follows at once
	assign chainFiq = finishEntry && curCause_r == EXC_DABT && fiqReq;
	assign entryStart = takeNow || chainFiq;
	assign entryCause = chainFiq ? EXC_FIQ : nextCause;
	assign returnTake = coreSync && state_r == ST_RUN && excReturn
		&& !takeNow && statusWord_r.mode != MODE_USR;

	always_comb begin
		saveEn = entryStart || resetRelease;
		saveBank = bankOf(modeOf(entryCause));
		saveLink = instrAddr + LINK_OFS;
		if (resetRelease) begin
			saveBank = BANK_SVC;
			saveLink = fetchAddr_r;
		end else if (chainFiq) begin
			// Fast return lands back on the abort handler entry
			saveLink = VEC_DABT + LINK_OFS;
		end else if (entryCause == EXC_DABT) begin
			saveLink = instrAddr + LINK_OFS_DABT;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_RESET;
			cnt_r <= '0;
			curCause_r <= EXC_NONE;
			entryBusy_r <= 1'b1;
		end else if (ce) begin
			if (!coreSync) begin
				state_r <= ST_RESET;
				entryBusy_r <= 1'b1;
			end else begin
				case (state_r)
					ST_RESET: begin
						state_r <= ST_RUN;
						entryBusy_r <= 1'b0;
					end
					ST_RUN: begin
						if (takeNow) begin
							state_r <= ST_ENTRY;
							entryBusy_r <= 1'b1;
							cnt_r <= entryLoad(nextCause);
							curCause_r <= nextCause;
						end
					end
					ST_ENTRY: begin
						if (chainFiq) begin
							cnt_r <= entryLoad(EXC_FIQ);
							curCause_r <= EXC_FIQ;
						end else if (cnt_r == '0) begin
							state_r <= ST_RUN;
							entryBusy_r <= 1'b0;
						end else begin
							cnt_r <= cnt_r - 1'b1;
						end
					end
					default: begin
						state_r <= ST_RESET;
						entryBusy_r <= 1'b1;
					end
				endcase
			end
		end
	end

	// Pending abort is sticky; a new abort in the take cycle is kept
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dabtPend_r <= 1'b0;
		end else if (ce) begin
			if (!coreSync) begin
				dabtPend_r <= 1'b0;
			end else if (dataAbort) begin
				dabtPend_r <= 1'b1;
			end else if (takeNow && nextCause == EXC_DABT) begin
				dabtPend_r <= 1'b0;
			end
		end
	end

	// Hardware updates override a same-cycle software write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			statusWord_r <= STATUS_RESET;
		end else if (ce) begin
			if (statusWrite) begin
				statusWord_r <= pwdata;
				statusWord_r.rsv <= '0;
			end
			if (resetRelease) begin
				statusWord_r.mode <= MODE_SVC;
				statusWord_r.irqMask <= 1'b1;
				statusWord_r.fiqMask <= 1'b1;
				statusWord_r.compact <= 1'b0;
			end else if (entryStart) begin
				statusWord_r.mode <= modeOf(entryCause);
				statusWord_r.irqMask <= 1'b1;
				statusWord_r.compact <= 1'b0;
				if (entryCause == EXC_FIQ) begin
					statusWord_r.fiqMask <= 1'b1;
				end
			end else if (returnTake) begin
				statusWord_r <= savedStatus_r[bankOf(statusWord_r.mode)];
			end
		end
	end

	generate
		for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					savedStatus_r[b] <= STATUS_RESET;
					linkReg_r[b] <= 32'h0;
				end else if (ce && saveEn && saveBank == 3'(b)) begin
					savedStatus_r[b] <= statusWord_r;
					linkReg_r[b] <= saveLink;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fetchAddr_r <= VEC_RESET;
			pcLoad_r <= 1'b0;
			takenCause_r <= EXC_NONE;
		end else if (ce) begin
			pcLoad_r <= 1'b0;
			if (!coreSync) begin
				fetchAddr_r <= fetchAddr_r + WORD_STEP;
			end else if (resetRelease) begin
				fetchAddr_r <= VEC_RESET;
				pcLoad_r <= 1'b1;
				takenCause_r <= EXC_RESET;
			end else if (finishEntry) begin
				fetchAddr_r <= vecOf(curCause_r);
				pcLoad_r <= 1'b1;
				takenCause_r <= curCause_r;
			end else if (returnTake) begin
				fetchAddr_r <= returnAddr;
				pcLoad_r <= 1'b1;
			end
		end
	end

	// APB slave, one wait state; writes land at the pready edge
	assign statusWrite = psel && penable && pready_r && pwrite && addrHit
		&& paddr == ADDR_W'(REG_STATUS) && statusWord_r.mode != MODE_USR;

	always_comb begin
		readData = 32'h0;
		addrHit = 1'b1;
		case (paddr)
			ADDR_W'(REG_STATUS): readData = statusWord_r;
			ADDR_W'(REG_FETCH): readData = fetchAddr_r;
			ADDR_W'(REG_CAUSE): readData = {29'h0, takenCause_r};
			ADDR_W'(REG_SVC_LINK): readData = linkReg_r[BANK_SVC];
			ADDR_W'(REG_SVC_SAVED): readData = savedStatus_r[BANK_SVC];
			default: addrHit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_r <= 32'h0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (ce) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			if (psel && penable && !pready_r) begin
				pready_r <= 1'b1;
				pslverr_r <= !addrHit;
				prdata_r <= pwrite ? 32'h0 : readData;
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign fetchAddr = fetchAddr_r;
	assign pcLoad = pcLoad_r;
	assign takenCause = takenCause_r;
	assign statusWord = statusWord_r;
	assign entryBusy = entryBusy_r;
	assign supervisorLinkRegister = linkReg_r[BANK_SVC];
	assign supervisorSavedStatus = savedStatus_r[BANK_SVC];

	a_prio_dabt_first: assert property (@(posedge clk)
		disable iff (!rst_b || !ce)
		takeNow && dabtPend_r |=> curCause_r == EXC_DABT)
		else $error("data abort lost arbitration");

	a_trap_exclusive: assert property (@(posedge clk)
		disable iff (!rst_b)
		!(undefHit && swHit))
		else $error("both traps raised");

	a_dabt_fiq_chain: assert property (@(posedge clk)
		disable iff (!rst_b || !ce)
		chainFiq |=> pcLoad_r && fetchAddr_r == VEC_DABT
			##1 pcLoad_r && fetchAddr_r == VEC_FIQ)
		else $error("abort to fast chain broken");

	a_dabt_entry_len: assert property (@(posedge clk)
		disable iff (!rst_b || !ce || !coreSync)
		takeNow && nextCause == EXC_DABT |=> !pcLoad_r [*2]
			##1 pcLoad_r && fetchAddr_r == VEC_DABT)
		else $error("abort entry not three cycles");

	a_fiq_entry_vec: assert property (@(posedge clk)
		disable iff (!rst_b || !ce || !coreSync)
		takeNow && nextCause == EXC_FIQ |=> !pcLoad_r
			##1 pcLoad_r && fetchAddr_r == VEC_FIQ && statusWord_r.fiqMask)
		else $error("fast entry not two cycles");

	a_irq_deferred: assert property (@(posedge clk)
		disable iff (!rst_b)
		takeNow && nextCause == EXC_IRQ |-> !fiqReq && !dabtPend_r)
		else $error("normal taken over fast");

	a_reset_fetch_inc: assert property (@(posedge clk)
		disable iff (!rst_b)
		rst_b && ce && !coreSync |=>
			fetchAddr_r == $past(fetchAddr_r) + WORD_STEP)
		else $error("reset fetch not incrementing");

	a_reset_save: assert property (@(posedge clk)
		disable iff (!rst_b || !ce)
		resetRelease |=> savedStatus_r[BANK_SVC] == $past(statusWord_r)
			&& linkReg_r[BANK_SVC] == $past(fetchAddr_r))
		else $error("reset save missing");

	a_reset_entry: assert property (@(posedge clk)
		disable iff (!rst_b || !ce)
		resetRelease |=> statusWord_r.mode == MODE_SVC
			&& statusWord_r.irqMask && statusWord_r.fiqMask
			&& !statusWord_r.compact && fetchAddr_r == VEC_RESET
			&& pcLoad_r)
		else $error("reset entry state wrong");

	a_mul_no_trap: assert property (@(posedge clk)
		disable iff (!rst_b)
		instrWord[27:22] == 6'h00 && instrWord[7:4] == 4'hd |-> !undefHit)
		else $error("multiply variant trapped");

	a_entry_save: assert property (@(posedge clk)
		disable iff (!rst_b || !ce)
		takeNow |=> statusWord_r.mode == modeOf(curCause_r)
			&& savedStatus_r[bankOf(statusWord_r.mode)] == $past(statusWord_r))
		else $error("entry save wrong");

	a_fiq_masks_irq: assert property (@(posedge clk)
		disable iff (!rst_b)
		pcLoad_r && takenCause_r == EXC_FIQ |-> statusWord_r.irqMask)
		else $error("fast entry left normal open");
endmodule
`default_nettype wire

// ### epr_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module epr_far_end
	import epr_pkg::*;
(
	input wire logic clk,
	output epr_pins_type pins,
	output logic dataAbort
);
	// Pins idle high; the bench asserts them by drive()
	initial begin
		pins = '{default: 1'b1};
		dataAbort = 1'b0;
	end

	task automatic drive(input epr_pins_type p);
		@(posedge clk);
		pins <= p;
	endtask

	// Single-cycle pulse: the unit must hold it pending by itself
	task automatic abort();
		@(posedge clk);
		dataAbort <= 1'b1;
		@(posedge clk);
		dataAbort <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import epr_pkg::*;
();
	localparam epr_pins_type IDLE = '{default: 1'b1};
	localparam logic [31:0] UND_W = 32'he600_0010;
	localparam logic [31:0] SWT_W = 32'hef00_0000;
	localparam logic [31:0] PLAIN_W = 32'he1a0_0000;
	localparam logic [31:0] MUL6_W = 32'he000_00d9;
	localparam logic [5:0] FIQ_V = 6'h03;
	localparam logic [5:0] IRQ_V = 6'h07;
	localparam logic [5:0] PABT_V = 6'h0f;
	localparam logic [31:0] VEC_T [6] = '{VEC_DABT, VEC_FIQ, VEC_IRQ,
		VEC_PABT, VEC_UNDEF, VEC_SWTRAP};
	localparam epr_exc_type CAUSE_T [6] = '{EXC_DABT, EXC_FIQ, EXC_IRQ,
		EXC_PABT, EXC_UNDEF, EXC_SWTRAP};
	localparam logic [4:0] MODE_T [6] = '{MODE_FIQ, MODE_FIQ, MODE_IRQ,
		MODE_ABT, MODE_UND, MODE_SVC};

	logic clk, rst_b, instrBoundary, instrPrefetchAbort;
	logic psel, penable, pwrite, pready, pslverr, pcLoad, entryBusy;
	logic dataAbort, er, excReturn;
	logic [7:0] paddr;
	logic [31:0] instrWord, pwdata, prdata, fetchAddr, supLink, rd, a;
	epr_pins_type pins;
	epr_exc_type takenCause;
	epr_status_type statusWord, supSaved;
	int error_cnt, cmp_count, n, m;

	always #2.5 clk = ~clk;

	epr_far_end far (.clk(clk), .pins(pins), .dataAbort(dataAbort));

	epr_exception_unit dut (.clk(clk), .rst_b(rst_b), .ce(1'b1),
		.coreReset_b(pins.coreReset_b), .fastIrq_b(pins.fastIrq_b),
		.normIrq_b(pins.normIrq_b), .instrBoundary(instrBoundary),
		.instrWord(instrWord), .instrCondPass(1'b1),
		.instrPrefetchAbort(instrPrefetchAbort), .instrAddr(32'h0000_0100),
		.dataAbort(dataAbort), .excReturn(excReturn),
		.returnAddr(VEC_DABT),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fetchAddr(fetchAddr), .pcLoad(pcLoad),
		.takenCause(takenCause), .statusWord(statusWord),
		.entryBusy(entryBusy), .supervisorLinkRegister(supLink),
		.supervisorSavedStatus(supSaved));

	task automatic chkWord(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkBit(input string what, input logic exp,
		input logic got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] ad,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chkBit("apb ready", 1'b1, pready);
	endtask

	// Counts edges until the vector load shows; gives up after lim
	task automatic waitLoad(input int lim, output int cnt);
		cnt = 0;
		do begin
			@(posedge clk);
			#1;
			cnt++;
		end while (pcLoad !== 1'b1 && cnt < lim);
	endtask

	task automatic boundary(input logic [31:0] w, input logic pa);
		@(posedge clk);
		instrBoundary <= 1'b1;
		instrWord <= w;
		instrPrefetchAbort <= pa;
		@(posedge clk);
		instrBoundary <= 1'b0;
		instrPrefetchAbort <= 1'b0;
	endtask

	// Pins must settle through the synchroniser before masks reopen
	task automatic unmask();
		far.drive(IDLE);
		repeat (4) @(posedge clk);
		apb(1'b1, REG_STATUS, 32'h0000_0013);
	endtask

	initial begin
		#50000;
		error_cnt++;
		$display("watchdog expired");
		print_verdict();
	end

	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		{instrBoundary, instrPrefetchAbort, psel, penable, pwrite} = '0;
		excReturn = 1'b0;
		paddr = 8'h00;
		instrWord = PLAIN_W;
		pwdata = 32'h0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (3) @(posedge clk);
		#1;
		chkWord("status in reset", STATUS_RESET, statusWord);
		chkBit("busy in reset", 1'b1, entryBusy);
		@(posedge clk);
		rst_b <= 1'b1;
		waitLoad(20, n);
		chkBit("reset load", 1'b1, pcLoad);
		chkWord("reset vector", VEC_RESET, fetchAddr);
		chkWord("reset cause", {29'h0, EXC_RESET}, {29'h0, takenCause});
		chkWord("reset status", STATUS_RESET, statusWord);
		$display("test reset done");
		apb(1'b0, REG_STATUS, 32'h0);
		chkWord("status reg", STATUS_RESET, rd);
		apb(1'b0, 8'h40, 32'h0);
		chkBit("unmapped error", 1'b1, er);
		apb(1'b1, REG_FETCH, 32'h0000_0100);
		apb(1'b0, REG_FETCH, 32'h0);
		chkWord("fetch reg", VEC_RESET, rd);
		$display("test registers done");
		for (int i = 0; i < 6; i++) begin
			unmask();
			far.drive('{coreReset_b: 1'b1, fastIrq_b: ~FIQ_V[i],
				normIrq_b: ~IRQ_V[i]});
			if (i == 0) begin
				far.abort();
			end
			repeat (4) @(posedge clk);
			boundary((i == 5) ? SWT_W : UND_W, PABT_V[i]);
			waitLoad(20, n);
			chkBit("vector load", 1'b1, pcLoad);
			chkWord("vector", VEC_T[i], fetchAddr);
			chkWord("cause", {29'h0, CAUSE_T[i]}, {29'h0, takenCause});
			if (i == 0) begin
				waitLoad(4, n);
				chkWord("chained vector", VEC_FIQ, fetchAddr);
				chkBit("chained at once", 1'b1, n == 1);
			end
			chkWord("mode", {27'h0, MODE_T[i]}, {27'h0, statusWord.mode});
			if (i < 2) begin
				chkBit("masks", 1'b1, statusWord.irqMask & statusWord.fiqMask);
			end
			if (i == 1) begin
				boundary(PLAIN_W, 1'b0);
				waitLoad(8, n);
				chkBit("normal deferred", 1'b0, pcLoad);
			end
			if (i == 0) begin
				@(posedge clk);
				excReturn <= 1'b1;
				@(posedge clk);
				excReturn <= 1'b0;
				#1;
				chkWord("fast return mode", {27'h0, MODE_ABT}, {27'h0, statusWord.mode});
			end
		end
		$display("test priority done");
		unmask();
		boundary(MUL6_W, 1'b0);
		waitLoad(8, n);
		chkBit("multiply bit6 no trap", 1'b0, pcLoad);
		$display("test decode done");
		unmask();
		@(posedge clk);
		instrBoundary <= 1'b1;
		far.drive('{coreReset_b: 1'b1, fastIrq_b: 1'b0, normIrq_b: 1'b1});
		waitLoad(20, n);
		@(posedge clk);
		instrBoundary <= 1'b0;
		chkBit("least latency", 1'b1, n >= LAT_MIN_CYC && n <= LAT_MIN_CYC + 1);
		unmask();
		far.drive('{coreReset_b: 1'b1, fastIrq_b: 1'b0, normIrq_b: 1'b1});
		far.abort();
		repeat (T_LDM_CYC - 2) @(posedge clk);
		boundary(PLAIN_W, 1'b0);
		waitLoad(20, n);
		waitLoad(4, m);
		chkBit("worst latency", 1'b1, T_LDM_CYC + 2 + n + m <= FIQ_LAT_MAX_CYC);
		chkWord("vector at worst", VEC_FIQ, fetchAddr);
		$display("test latency done");
		unmask();
		apb(1'b1, REG_STATUS, 32'h0000_0010);
		apb(1'b1, REG_STATUS, 32'h0000_0013);
		apb(1'b0, REG_STATUS, 32'h0);
		chkWord("user write refused", 32'h0000_0010, rd);
		far.drive('{coreReset_b: 1'b0, fastIrq_b: 1'b1, normIrq_b: 1'b1});
		repeat (4) @(posedge clk);
		#1;
		a = fetchAddr;
		@(posedge clk);
		#1;
		chkWord("reset walk", a + WORD_STEP, fetchAddr);
		chkBit("busy while held", 1'b1, entryBusy);
		far.drive(IDLE);
		waitLoad(20, n);
		chkWord("release vector", VEC_RESET, fetchAddr);
		chkWord("release status", STATUS_RESET, statusWord);
		chkWord("saved status", 32'h0000_0010, supSaved);
		chkWord("saved link", a + (WORD_STEP << 2), supLink);
		apb(1'b0, REG_SVC_SAVED, 32'h0);
		chkWord("saved status reg", 32'h0000_0010, rd);
		$display("test core reset done");
		print_verdict();
	end
endmodule
`default_nettype wire
